//--- verilog/ptsc_pkg.sv
// constants, register map and types of the timestamp clock synchroniser
package ptsc_pkg;

  // clock and time figures
  localparam int unsigned CLK_HZ          = 200_000_000;
  localparam logic [2:0]  STEP_NS         = 3'h5;
  localparam logic [29:0] NS_PER_SEC      = 30'h3b9aca00;
  localparam logic signed [31:0] NS_HALF  = 32'sh1dcd6500;
  localparam logic signed [31:0] NS_FULL  = 32'sh3b9aca00;
  localparam int unsigned MISS_WINDOW_MS  = 1500;
  localparam int unsigned EARLY_WINDOW_MS = 500;
  localparam int unsigned MISS_CYC_DEF    = MISS_WINDOW_MS * (CLK_HZ / 1000);
  localparam int unsigned EARLY_CYC_DEF   = EARLY_WINDOW_MS * (CLK_HZ / 1000);
  localparam int unsigned OUT_PULSE_NS    = 1000;
  localparam int unsigned CLK_PERIOD_NS   = 1_000_000_000 / CLK_HZ;
  localparam logic [15:0] OUT_PULSE_CYC   =
    16'((OUT_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [31:0] THRESH_NS_DEF   = 32'h00000254;
  localparam int unsigned SYNC_TIMEOUT_S  = 60;
  localparam int unsigned FREQ_GAIN_SH    = 4;

  // register byte addresses
  localparam logic [7:0] REG_CTRL     = 8'h00;
  localparam logic [7:0] REG_CMD      = 8'h04;
  localparam logic [7:0] REG_LOAD_SEC = 8'h08;
  localparam logic [7:0] REG_LOAD_NS  = 8'h0c;
  localparam logic [7:0] REG_THRESH   = 8'h10;
  localparam logic [7:0] REG_STATUS   = 8'h14;
  localparam logic [7:0] REG_TIME_SEC = 8'h18;
  localparam logic [7:0] REG_TIME_NS  = 8'h1c;
  localparam logic [7:0] REG_PHASE    = 8'h20;
  localparam logic [7:0] REG_FREQ     = 8'h24;
  localparam logic [7:0] REG_WPHASE   = 8'h28;
  localparam logic [7:0] REG_WFREQ    = 8'h2c;
  localparam logic [7:0] REG_TOTAL    = 8'h30;
  localparam logic [7:0] REG_BAD      = 8'h34;
  localparam logic [7:0] REG_SINGLES  = 8'h38;
  localparam logic [7:0] REG_LONGEST  = 8'h3c;
  localparam logic [7:0] REG_FAILS    = 8'h40;
  localparam logic [7:0] REG_IRQ_STAT = 8'h44;
  localparam logic [7:0] REG_IRQ_MASK = 8'h48;

  // field positions
  localparam int CTRL_IN_LSB  = 0;
  localparam int CTRL_OUT_LSB = 4;
  localparam int CMD_SET      = 0;
  localparam int CMD_RESET    = 1;
  localparam int CMD_CLR      = 2;
  localparam int CMD_MARK     = 3;
  localparam int IRQ_W        = 4;

  // input source choices
  typedef enum logic [2:0] {
    IN_NONE   = 3'b000,
    IN_SERIAL = 3'b001,
    IN_HOST   = 3'b010,
    IN_OVER   = 3'b011,
    IN_AUX    = 3'b100
  } ptsc_in_e;

  // output source choices
  typedef enum logic [2:0] {
    OUT_NONE     = 3'b000,
    OUT_REPEAT   = 3'b001,
    OUT_LOOP     = 3'b010,
    OUT_HOST     = 3'b011,
    OUT_INTERNAL = 3'b100
  } ptsc_out_e;

endpackage : ptsc_pkg

//--- verilog/ptsc_cnt.sv
// clearable event counter for the pulse statistics
`timescale 1ns/1ps
module ptsc_cnt #(
  parameter int W = 32
) (
  input  wire logic         clk_sys,
  input  wire logic         rst,
  input  wire logic         clr,
  input  wire logic         inc,
  output logic [W-1:0]      count
);
  import ptsc_pkg::*;

  typedef struct packed {
    logic [W-1:0] cnt;
  } ptsc_cnt_s;

  ptsc_cnt_s r;
  ptsc_cnt_s n;

  // count up, clear wins; saturates at all ones
  always_comb
  begin
    n = r;
    if (clr)
      n.cnt = '0;
    else if (inc && (r.cnt != {W{1'b1}}))
      n.cnt = r.cnt + 1'b1;
  end

  // state register
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      r <= '0;
    else
      r <= n;
  end

  assign count = r.cnt;

endmodule : ptsc_cnt

//--- verilog/ptsc_peak.sv
// worst absolute value tracker for the error reports
`timescale 1ns/1ps
module ptsc_peak #(
  parameter int W = 32
) (
  input  wire logic                clk_sys,
  input  wire logic                rst,
  input  wire logic                clr,
  input  wire logic                upd,
  input  wire logic signed [W-1:0] value,
  output logic [W-1:0]             peak
);
  import ptsc_pkg::*;

  typedef struct packed {
    logic [W-1:0] pk;
  } ptsc_peak_s;

  ptsc_peak_s  r;
  ptsc_peak_s  n;
  logic [W-1:0] mag;

  // magnitude of the new sample
  assign mag = value[W-1] ? W'(-value) : W'(value);

  // keep the largest magnitude seen
  always_comb
  begin
    n = r;
    if (clr)
      n.pk = '0;
    else if (upd && (mag > r.pk))
      n.pk = mag;
  end

  // state register
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      r <= '0;
    else
      r <= n;
  end

  assign peak = r.pk;

endmodule : ptsc_peak

//--- verilog/ptsc_top.sv
// timestamp clock with pulse discipline, sync output selector and statistics
//
// Our own choices: strobed register access and the address map.
`timescale 1ns/1ps
module ptsc_top #(
  parameter int unsigned MISS_CYC  = ptsc_pkg::MISS_CYC_DEF,
  parameter int unsigned EARLY_CYC = ptsc_pkg::EARLY_CYC_DEF
) (
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic [31:0]      reg_rdata,
  input  wire logic        second_pulse_in,
  output logic             sync_out,
  output logic             sync_oe,
  output logic             irq
);
  import ptsc_pkg::*;

  typedef struct packed {
    ptsc_in_e           in_sel;
    ptsc_out_e          out_sel;
    logic [31:0]        ld_sec;
    logic [29:0]        ld_ns;
    logic [31:0]        thresh;
    logic [31:0]        sec;
    logic [29:0]        ns;
    logic [31:0]        frac;
    logic signed [31:0] freq_adj;
    logic [29:0]        snap_ns;
    logic [31:0]        rdata;
    logic               synced;
    logic               have_last;
    logic signed [31:0] phase;
    logic signed [31:0] freq;
    logic [31:0]        gap_cnt;
    logic [15:0]        miss_run;
    logic [15:0]        longest;
    logic [IRQ_W-1:0]   irq_st;
    logic [IRQ_W-1:0]   irq_mask;
    logic               irq;
    logic               sel_d;
    logic [15:0]        out_cnt;
    logic               sync_out;
    logic               sync_oe;
  } ptsc_state_s;

  ptsc_state_s        r;
  ptsc_state_s        n;
  logic               wr_cmd;
  logic               cmd_set;
  logic               cmd_rst;
  logic               cmd_clr;
  logic               cmd_mark;
  logic               sel_lvl;
  logic               evt_pulse;
  logic               evt_bad;
  logic               evt_ok;
  logic               miss;
  logic               fail;
  logic               single;
  logic [29:0]        ref_ns;
  logic signed [31:0] dph;
  logic [31:0]        dabs;
  logic signed [33:0] fsum;
  logic [2:0]         step;
  logic [29:0]        ns_inc;
  logic [2:0]         wsel;
  logic [IRQ_W-1:0]   events;
  logic [31:0]        total_cnt;
  logic [31:0]        bad_cnt;
  logic [31:0]        single_cnt;
  logic [31:0]        fail_cnt;
  logic [31:0]        worst_ph;
  logic [31:0]        worst_fr;

  // command strobes from the command register
  assign wr_cmd   = reg_wr && (reg_addr == REG_CMD);
  assign cmd_set  = wr_cmd && reg_wdata[CMD_SET];
  assign cmd_rst  = wr_cmd && reg_wdata[CMD_RESET];
  assign cmd_clr  = wr_cmd && reg_wdata[CMD_CLR];
  assign cmd_mark = wr_cmd && reg_wdata[CMD_MARK];

  // input selector; host and aux inputs are unused and read low
  always_comb
  begin
    case (r.in_sel)
      IN_SERIAL: sel_lvl = second_pulse_in;
      default:   sel_lvl = 1'b0;
    endcase
  end

  // reference events: serial pulse edge, or a host time mark
  assign evt_pulse = (r.in_sel == IN_SERIAL) ? (sel_lvl && !r.sel_d)
                   : ((r.in_sel == IN_OVER) && cmd_mark);
  assign evt_bad   = evt_pulse && r.have_last && (r.gap_cnt < 32'(EARLY_CYC));
  assign evt_ok    = evt_pulse && !evt_bad;
  assign miss      = (r.in_sel == IN_SERIAL) && (r.gap_cnt >= 32'(MISS_CYC));
  assign single    = evt_ok && (r.miss_run == 16'h0001);

  // phase error against the second boundary or the host mark time
  always_comb
  begin
    ref_ns = (r.in_sel == IN_OVER) ? r.ld_ns : 30'h0;
    dph    = $signed({2'b00, r.ns}) - $signed({2'b00, ref_ns});
    if (dph > NS_HALF)
      dph = dph - NS_FULL;
    else if (dph < -NS_HALF)
      dph = dph + NS_FULL;
    dabs = dph[31] ? 32'(-dph) : 32'(dph);
  end

  assign fail   = evt_ok && (dabs > r.thresh);
  assign events = {fail, miss, evt_bad, evt_ok};

  // rate trimmed counter step: nominal period plus fractional carry
  assign fsum   = $signed({2'b00, r.frac}) + $signed({{2{r.freq_adj[31]}}, r.freq_adj});
  assign step   = fsum[33] ? (STEP_NS - 3'h1) : (fsum[32] ? (STEP_NS + 3'h1) : STEP_NS);
  assign ns_inc = r.ns + 30'(step);
  assign wsel   = reg_wdata[CTRL_IN_LSB +: 3];

  // next state
  always_comb
  begin
    n          = r;
    n.sel_d    = sel_lvl;
    n.frac     = fsum[31:0];
    n.out_cnt  = (r.out_cnt != 16'h0) ? (r.out_cnt - 16'h1) : 16'h0;

    // free running time of day
    if (ns_inc >= NS_PER_SEC)
    begin
      n.ns      = ns_inc - NS_PER_SEC;
      n.sec     = r.sec + 32'h1;
      n.out_cnt = OUT_PULSE_CYC;
    end
    else
      n.ns = ns_inc;

    // pulse gap watchdog
    if (evt_pulse)
      n.gap_cnt = 32'h0;
    else if (miss)
      n.gap_cnt = 32'(EARLY_CYC);  // next miss one second later
    else if (r.gap_cnt != 32'hffffffff)
      n.gap_cnt = r.gap_cnt + 32'h1;

    // missed pulse runs
    if (miss)
    begin
      n.miss_run = r.miss_run + 16'h1;
      if ((r.miss_run + 16'h1) > r.longest)
        n.longest = r.miss_run + 16'h1;
    end

    // discipline on each valid reference event
    if (evt_ok)
    begin
      n.have_last = 1'b1;
      n.miss_run  = 16'h0;
      n.phase     = dph;
      n.freq      = r.have_last ? (dph - r.phase) : 32'sh0;
      if (fail)
      begin
        n.synced = 1'b0;
        n.ns     = ref_ns;
        n.frac   = 32'h0;
        if (r.in_sel == IN_OVER)
          n.sec = r.ld_sec;
      end
      else
      begin
        n.synced   = 1'b1;
        n.freq_adj = r.freq_adj - (dph <<< FREQ_GAIN_SH);
      end
    end

    // statistics clear
    if (cmd_clr)
    begin
      n.miss_run = 16'h0;
      n.longest  = 16'h0;
    end

    // host load of the counter
    if (cmd_set || cmd_rst)
    begin
      n.sec       = r.ld_sec;
      n.ns        = r.ld_ns;
      n.frac      = 32'h0;
      n.synced    = 1'b0;
      n.have_last = 1'b0;
      n.gap_cnt   = 32'h0;
    end
    if (cmd_rst)
    begin
      n.in_sel   = IN_SERIAL;
      n.out_sel  = OUT_NONE;
      n.freq_adj = 32'sh0;
    end

    // register writes
    if (reg_wr)
    begin
      case (reg_addr)
        REG_CTRL:
        begin
          n.in_sel  = (wsel > IN_AUX) ? IN_NONE : ptsc_in_e'(wsel);
          n.out_sel = (reg_wdata[CTRL_OUT_LSB +: 3] > OUT_INTERNAL) ? OUT_NONE
                    : ptsc_out_e'(reg_wdata[CTRL_OUT_LSB +: 3]);
        end
        REG_LOAD_SEC: n.ld_sec   = reg_wdata;
        REG_LOAD_NS:  n.ld_ns    = reg_wdata[29:0];
        REG_THRESH:   n.thresh   = reg_wdata;
        REG_IRQ_MASK: n.irq_mask = reg_wdata[IRQ_W-1:0];
        default:      n.irq_mask = r.irq_mask;
      endcase
    end

    // sticky events, write one to clear, a new event wins
    n.irq_st = r.irq_st & ~((reg_wr && (reg_addr == REG_IRQ_STAT))
                            ? reg_wdata[IRQ_W-1:0] : {IRQ_W{1'b0}});
    n.irq_st = n.irq_st | events;
    n.irq    = |(n.irq_st & n.irq_mask);

    // sync output selector
    case (r.out_sel)
      OUT_REPEAT:   n.sync_out = second_pulse_in;
      OUT_LOOP:     n.sync_out = sel_lvl;
      OUT_INTERNAL: n.sync_out = (r.out_cnt != 16'h0);
      default:      n.sync_out = 1'b0;
    endcase
    n.sync_oe = (r.out_sel != OUT_NONE);

    // read data, valid the cycle after the strobe
    n.rdata = 32'h0;
    if (reg_rd)
    begin
      case (reg_addr)
        REG_CTRL:     n.rdata = {25'h0, r.out_sel, 1'b0, r.in_sel};
        REG_LOAD_SEC: n.rdata = r.ld_sec;
        REG_LOAD_NS:  n.rdata = {2'b00, r.ld_ns};
        REG_THRESH:   n.rdata = r.thresh;
        REG_STATUS:   n.rdata = {31'h0, r.synced};
        REG_TIME_SEC:
        begin
          n.rdata   = r.sec;
          n.snap_ns = r.ns;  // ns read later pairs with this second
        end
        REG_TIME_NS:  n.rdata = {2'b00, r.snap_ns};
        REG_PHASE:    n.rdata = r.phase;
        REG_FREQ:     n.rdata = r.freq;
        REG_WPHASE:   n.rdata = worst_ph;
        REG_WFREQ:    n.rdata = worst_fr;
        REG_TOTAL:    n.rdata = total_cnt;
        REG_BAD:      n.rdata = bad_cnt;
        REG_SINGLES:  n.rdata = single_cnt;
        REG_LONGEST:  n.rdata = {16'h0, r.longest};
        REG_FAILS:    n.rdata = fail_cnt;
        REG_IRQ_STAT: n.rdata = {{(32-IRQ_W){1'b0}}, r.irq_st};
        REG_IRQ_MASK: n.rdata = {{(32-IRQ_W){1'b0}}, r.irq_mask};
        default:      n.rdata = 32'h0;
      endcase
    end
  end

  // state register; defaults select the serial pulse, output off
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      r         <= '0;
      r.in_sel  <= IN_SERIAL;
      r.out_sel <= OUT_NONE;
      r.thresh  <= THRESH_NS_DEF;
    end
    else
      r <= n;
  end

  // pulse statistics
  ptsc_cnt #(.W(32)) u_total (
    .clk_sys (clk_sys),
    .rst     (rst),
    .clr     (cmd_clr),
    .inc     (evt_pulse),
    .count   (total_cnt)
  );
  ptsc_cnt #(.W(32)) u_bad (
    .clk_sys (clk_sys),
    .rst     (rst),
    .clr     (cmd_clr),
    .inc     (evt_bad),
    .count   (bad_cnt)
  );
  ptsc_cnt #(.W(32)) u_single (
    .clk_sys (clk_sys),
    .rst     (rst),
    .clr     (cmd_clr),
    .inc     (single),
    .count   (single_cnt)
  );
  ptsc_cnt #(.W(32)) u_fail (
    .clk_sys (clk_sys),
    .rst     (rst),
    .clr     (cmd_clr),
    .inc     (fail),
    .count   (fail_cnt)
  );

  // worst errors since start or last clear
  ptsc_peak #(.W(32)) u_wph (
    .clk_sys (clk_sys),
    .rst     (rst),
    .clr     (cmd_clr),
    .upd     (evt_ok),
    .value   (dph),
    .peak    (worst_ph)
  );
  ptsc_peak #(.W(32)) u_wfr (
    .clk_sys (clk_sys),
    .rst     (rst),
    .clr     (cmd_clr),
    .upd     (evt_ok && r.have_last),
    .value   (dph - r.phase),
    .peak    (worst_fr)
  );

  assign reg_rdata = r.rdata;
  assign sync_out  = r.sync_out;
  assign sync_oe   = r.sync_oe;
  assign irq       = r.irq;

endmodule : ptsc_top

//--- dv/ptsc_properties.sv
// port-level checks of the timestamp clock synchroniser
`timescale 1ns/1ps
module ptsc_properties
  import ptsc_pkg::*;
#(
  parameter int unsigned MISS_CYC  = ptsc_pkg::MISS_CYC_DEF,
  parameter int unsigned EARLY_CYC = ptsc_pkg::EARLY_CYC_DEF
) (
  input wire logic        clk_sys,
  input wire logic        rst,
  input wire logic [7:0]  reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic        second_pulse_in,
  input wire logic        sync_out,
  input wire logic        sync_oe,
  input wire logic        irq
);
  logic [2:0]  in_r;
  logic [2:0]  out_r;
  logic [15:0] hi_cnt_r;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  // mirror of the selectors and length of the current sync_out high run
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      in_r     <= IN_SERIAL;
      out_r    <= OUT_NONE;
      hi_cnt_r <= 16'h0000;
    end
    else
    begin
      hi_cnt_r <= sync_out ? hi_cnt_r + 16'h0001 : 16'h0000;
      if (reg_wr && reg_addr == REG_CTRL)
      begin
        in_r  <= (reg_wdata[2:0] > 3'h4) ? 3'h0 : reg_wdata[2:0];
        out_r <= (reg_wdata[6:4] > 3'h4) ? 3'h0 : reg_wdata[6:4];
      end
      else if (reg_wr && reg_addr == REG_CMD && reg_wdata[CMD_RESET])
      begin
        in_r  <= IN_SERIAL;
        out_r <= OUT_NONE;
      end
    end
  end

  // mask cleared and read of an unmapped place
  sequence s_mask_off;
    reg_wr && reg_addr == REG_IRQ_MASK && reg_wdata[IRQ_W-1:0] == 4'h0;
  endsequence
  sequence s_bad_rd;
    reg_rd && reg_addr > REG_IRQ_MASK;
  endsequence

  rdata_idle_a: assert property (!reg_rd |=> reg_rdata == 32'h00000000)
    else $error("read data not zero outside an answer");
  reset_idle_a: assert property ($fell(rst) |-> !sync_oe && !irq)
    else $error("outputs active after reset");
  unmapped_rd_a: assert property (s_bad_rd |=> reg_rdata == 32'h00000000)
    else $error("unmapped read not zero");
  repeat_follow_a: assert property ($past(out_r) == OUT_REPEAT |->
    sync_oe && sync_out == $past(second_pulse_in)) else $error("repeat output wrong");
  loop_follow_a: assert property ($past(out_r) == OUT_LOOP && $past(in_r) == IN_SERIAL |->
    sync_oe && sync_out == $past(second_pulse_in)) else $error("loop output wrong");
  none_quiet_a: assert property ($past(out_r) == OUT_NONE |-> !sync_oe)
    else $error("sync output driven with no output choice");
  host_out_a: assert property ($past(out_r) == OUT_HOST |-> sync_oe && !sync_out)
    else $error("host output choice wrong");
  master_width_a: assert property ($fell(sync_out) && $past(out_r) == OUT_INTERNAL |->
    hi_cnt_r == OUT_PULSE_CYC) else $error("master pulse width wrong");
  irq_mask_a: assert property (s_mask_off |-> ##2 !irq)
    else $error("interrupt stays high after masking");
endmodule : ptsc_properties

bind ptsc_top ptsc_properties #(.MISS_CYC(MISS_CYC), .EARLY_CYC(EARLY_CYC)) u_props (
  .clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .second_pulse_in(second_pulse_in), .sync_out(sync_out), .sync_oe(sync_oe), .irq(irq));

//--- dv/ptsc_pulse_ref.sv
// far-end second pulse source with a programmable delay
`timescale 1ns/1ps
module ptsc_pulse_ref (
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic        arm,
  input  wire logic [31:0] gap,
  output logic             second_pulse_in,
  output logic             busy
);
  logic [31:0] wait_r;
  logic [2:0]  width_r;

  // wait the requested gap, then hold the pulse high for four cycles
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      wait_r          <= 32'h0;
      width_r         <= 3'h0;
      busy            <= 1'b0;
      second_pulse_in <= 1'b0;
    end
    else if (arm)
    begin
      wait_r <= gap;
      busy   <= 1'b1;
    end
    else if (busy && wait_r != 32'h0)
      wait_r <= wait_r - 32'h1;
    else if (busy && width_r != 3'h4)
    begin
      second_pulse_in <= 1'b1;
      width_r         <= width_r + 3'h1;
    end
    else
    begin
      second_pulse_in <= 1'b0;
      width_r         <= 3'h0;
      busy            <= 1'b0;
    end
  end
endmodule : ptsc_pulse_ref

//--- dv/testbench.sv
// self-checking bench for the timestamp clock synchroniser
`timescale 1ns/1ps
module testbench;
  import ptsc_pkg::*;
  logic        clk_sys, rst, reg_wr, reg_rd, second_pulse_in, sync_out, sync_oe, irq, arm, busy;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata, reg_rdata, gap, rdat;
  int          errors, checks;

  always #2.5 clk_sys = ~clk_sys;

  ptsc_top #(.MISS_CYC(300), .EARLY_CYC(100)) DUT (.clk_sys(clk_sys), .rst(rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .second_pulse_in(second_pulse_in), .sync_out(sync_out),
    .sync_oe(sync_oe), .irq(irq));
  ptsc_pulse_ref u_ref (.clk_sys(clk_sys), .rst(rst), .arm(arm), .gap(gap),
    .second_pulse_in(second_pulse_in), .busy(busy));

  // verdict and end of run
  task automatic close_out();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : close_out

  // comparisons
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic rng(input logic [31:0] got, input logic [31:0] lo, input logic [31:0] hi);
    checks++;
    if ((got >= lo && got <= hi) !== 1'b1)
    begin
      errors++;
      $display("wrong value at %0t: got %h expected %h to %h", $time, got, lo, hi);
    end
  endtask : rng

  // register bus cycles
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask : rd
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    rd(a, d);
    chk(d, exp);
  endtask : rd_chk
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : tick

  // far-end pulse after a gap, then a bounded wait for it to finish
  task automatic launch(input logic [31:0] g);
    @(posedge clk_sys);
    gap <= g;
    arm <= 1'b1;
    @(posedge clk_sys);
    arm <= 1'b0;
  endtask : launch
  task automatic fire(input logic [31:0] g);
    int n;
    launch(g);
    n = 0;
    do
    begin
      @(posedge clk_sys);
      n++;
    end
    while (busy !== 1'b0 && n < 2000);
    if (n >= 2000)
    begin
      errors++;
      close_out();
    end
  endtask : fire
  task automatic follow(input logic [31:0] ctrl);
    int n;
    wr(REG_CTRL, ctrl);
    launch(32'h5);
    n = 0;
    while (second_pulse_in !== 1'b1 && n < 50)
    begin
      @(posedge clk_sys);
      n++;
    end
    // a pulse that never shows up ends the run as a failure
    if (n >= 50)
    begin
      errors++;
      close_out();
    end
    #1;
    chk(sync_out, 1'b1);
    tick(8);
  endtask : follow

  // main sequence
  initial
  begin
    clk_sys = 1'b0;
    rst = 1'b1;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    arm = 1'b0;
    gap = 32'h0;
    errors = 0;
    checks = 0;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    rd_chk(REG_CTRL, 32'h00000001);
    rd_chk(REG_THRESH, THRESH_NS_DEF);
    chk(sync_oe, 1'b0);
    rd_chk(8'h4c, 32'h0);
    for (int i = 0; i < 8; i++)
    begin
      wr(REG_CTRL, 32'(i) * 32'h11);
      rd_chk(REG_CTRL, (i < 5) ? 32'(i) * 32'h11 : 32'h0);
      chk(sync_oe, (i > 0 && i < 5));
    end
    // host-following input ignores the pulse line and takes host marks
    wr(REG_CTRL, 32'h3);
    fire(32'h96);
    rd_chk(REG_TOTAL, 32'h0);
    wr(REG_LOAD_NS, 32'h0);
    wr(REG_CMD, 32'h8);
    rd_chk(REG_TOTAL, 32'h1);
    wr(REG_CMD, 32'h4);
    rd_chk(REG_TOTAL, 32'h0);
    wr(REG_CTRL, 32'h41);
    wr(REG_CMD, 32'h2);
    rd_chk(REG_CTRL, 32'h1);
    // set keeps the selectors, seconds roll over, master pulse follows
    wr(REG_CTRL, 32'h41);
    wr(REG_LOAD_SEC, 32'h5);
    wr(REG_LOAD_NS, 32'h3b9ac99c);
    wr(REG_CMD, 32'h1);
    rd_chk(REG_CTRL, 32'h41);
    tick(30);
    rd_chk(REG_TIME_SEC, 32'h6);
    chk(sync_out, 1'b1);
    rd_chk(REG_TIME_NS, 32'h00000041);
    tick(250);
    chk(sync_out, 1'b0);
    follow(32'h11);
    follow(32'h21);
    // disciplined pulse, interrupt, early pulse, one miss, failure
    wr(REG_CTRL, 32'h1);
    wr(REG_CMD, 32'h4);
    wr(REG_IRQ_STAT, 32'hf);
    wr(REG_LOAD_NS, 32'h3b9ac794);
    wr(REG_CMD, 32'h1);
    fire(32'h78);
    rd_chk(REG_STATUS, 32'h1);
    rd_chk(REG_TOTAL, 32'h1);
    rd_chk(REG_PHASE, 32'hfffffffb);
    rd_chk(REG_IRQ_STAT, 32'h1);
    wr(REG_IRQ_MASK, 32'h1);
    tick(2);
    chk(irq, 1'b1);
    wr(REG_IRQ_MASK, 32'h0);
    tick(2);
    chk(irq, 1'b0);
    wr(REG_IRQ_MASK, 32'h1);
    wr(REG_IRQ_STAT, 32'h1);
    tick(2);
    chk(irq, 1'b0);
    rd_chk(REG_IRQ_STAT, 32'h0);
    fire(32'h14);
    rd_chk(REG_BAD, 32'h1);
    fire(32'h19f);
    rd_chk(REG_SINGLES, 32'h1);
    rd_chk(REG_LONGEST, 32'h1);
    rd_chk(REG_STATUS, 32'h0);
    rd_chk(REG_FAILS, 32'h1);
    rd(REG_WPHASE, rdat);
    rng(rdat, 32'h258, 32'h1388);
    wr(REG_CMD, 32'h4);
    rd_chk(REG_BAD, 32'h0);
    rd_chk(REG_SINGLES, 32'h0);
    close_out();
  end
endmodule : testbench
